/* hdl/po_sel_pkg.sv */
// Contract
// - codes 01-04 follow weld, weld plus hold, hold, off interval.
// - code 05 asserts after off ends until initiation is withdrawn.
// - code 06 gives one half-second pulse from the sequence end point.
// - codes 07, 08, 09 select retraction and half-cycle special functions.
// - code 10 asserts on fault, no weld, programming, stop, current out of window; the code shows out-of-window current only while i_const_current is set.
// - code 11 asserts while the thermal limit switch reads open.
// - code 12 only flashes the limit indication on out-of-window current.
// - code 13 flashes limit indication and pulses valve three half a second.
// - code 14 flashes limit indication and breaks the running sequence.
// - code 15 asserts on hardware fault or control relay fault.
// - code 16 asserts on shorted thyristor or missing second line.
// - code 17 asserts on thermal, memory, compensation, stepper end faults.
// - code 18 asserts when full thyristor conduction is detected.
// - code 19 asserts in weld only in weld mode with inhibit input closed.
// - code 20 asserts from squeeze completion through the weld interval.
// - code 22 sends result and current after bad weld or last weld.
// - code 23 sends result and current on out-of-window current.
// - code 25 also presents measured current on the data display.
// - code 27 flashes, breaks sequence and pulses valve three.
// - code 28 pulses valve three at sequence end if all is good.
package po_sel_pkg;
  localparam int CODE_W = 5;
  localparam int CUR_W  = 16;
  localparam int PCNT_W = 24;
  localparam logic [CODE_W-1:0] CODE_RST        = 5'h00;
  localparam logic [CODE_W-1:0] CODE_DISABLED   = 5'h00;
  localparam logic [CODE_W-1:0] CODE_WELD       = 5'h01;
  localparam logic [CODE_W-1:0] CODE_WELD_HOLD  = 5'h02;
  localparam logic [CODE_W-1:0] CODE_HOLD       = 5'h03;
  localparam logic [CODE_W-1:0] CODE_OFF        = 5'h04;
  localparam logic [CODE_W-1:0] CODE_AFTER_OFF  = 5'h05;
  localparam logic [CODE_W-1:0] CODE_END_PULSE  = 5'h06;
  localparam logic [CODE_W-1:0] CODE_AIR_OIL    = 5'h07;
  localparam logic [CODE_W-1:0] CODE_RETRACT    = 5'h08;
  localparam logic [CODE_W-1:0] CODE_HALF_CYC   = 5'h09;
  localparam logic [CODE_W-1:0] CODE_ANY_FAULT  = 5'h0a;
  localparam logic [CODE_W-1:0] CODE_THERMAL    = 5'h0b;
  localparam logic [CODE_W-1:0] CODE_FLASH      = 5'h0c;
  localparam logic [CODE_W-1:0] CODE_FLASH_V3   = 5'h0d;
  localparam logic [CODE_W-1:0] CODE_FLASH_BRK  = 5'h0e;
  localparam logic [CODE_W-1:0] CODE_HW_FAULT   = 5'h0f;
  localparam logic [CODE_W-1:0] CODE_SCR_SHORT  = 5'h10;
  localparam logic [CODE_W-1:0] CODE_FAULT_GRP  = 5'h11;
  localparam logic [CODE_W-1:0] CODE_FULL_COND  = 5'h12;
  localparam logic [CODE_W-1:0] CODE_WELD_OK    = 5'h13;
  localparam logic [CODE_W-1:0] CODE_INTERLOCK  = 5'h14;
  localparam logic [CODE_W-1:0] CODE_RSVD_A     = 5'h15;
  localparam logic [CODE_W-1:0] CODE_TX_LAST    = 5'h16;
  localparam logic [CODE_W-1:0] CODE_TX_OUT     = 5'h17;
  localparam logic [CODE_W-1:0] CODE_SHOW_CUR   = 5'h19;
  localparam logic [CODE_W-1:0] CODE_FLASH_ALL  = 5'h1b;
  localparam logic [CODE_W-1:0] CODE_END_V3     = 5'h1c;
  localparam logic [CODE_W-1:0] CODE_RSVD_B     = 5'h1d;
  localparam int MCLK_KHZ       = 25000;
  localparam int PULSE_MS       = 500;
  localparam int PULSE_CYCLES   = MCLK_KHZ * PULSE_MS;
endpackage : po_sel_pkg

/* hdl/pulse_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pulse_if;
  logic fire;
  logic busy;
  modport req (output fire, input busy);
  modport tmr (input fire, output busy);
endinterface : pulse_if
`default_nettype wire

/* hdl/half_sec_pulse.sv */
`timescale 1ns/10ps
`default_nettype none
module half_sec_pulse
  import po_sel_pkg::*;
#(
  parameter int unsigned CYCLES = PULSE_CYCLES
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  // trigger and pulse
  pulse_if.tmr      p
);
  typedef struct packed {
    logic              busy;
    logic [PCNT_W-1:0] cnt;
  } tmr_s;
  tmr_s st_q;
  tmr_s st_d;

  // a trigger during a running pulse is ignored, no stretching
  always_comb begin
    st_d = st_q;
    if (st_q.busy) begin
      if (st_q.cnt == '0) begin
        st_d.busy = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end else if (p.fire) begin
      st_d.busy = 1'b1;
      st_d.cnt  = PCNT_W'(CYCLES - 1);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign p.busy = st_q.busy;
endmodule : half_sec_pulse
`default_nettype wire

/* hdl/code_store.sv */
`timescale 1ns/10ps
`default_nettype none
module code_store
  import po_sel_pkg::*;
(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  // write side
  input  wire logic              i_prog_mode,
  input  wire logic              i_wr,
  input  wire logic [CODE_W-1:0] i_wdata,
  // stored code
  output logic      [CODE_W-1:0] o_code
);
  typedef struct packed {
    logic [CODE_W-1:0] code;
  } store_s;
  store_s st_q;
  store_s st_d;

  // writes outside programming mode are dropped silently
  always_comb begin
    st_d = st_q;
    if (i_prog_mode && i_wr) begin
      st_d.code = i_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '{code: CODE_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_code = st_q.code;
endmodule : code_store
`default_nettype wire

/* hdl/weld_process_output_select.sv */
`timescale 1ns/10ps
`default_nettype none
module weld_process_output_select
  import po_sel_pkg::*;
#(
  parameter int unsigned P_PULSE_CYCLES = PULSE_CYCLES
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  // selection code programming
  input  wire logic             i_prog_mode,
  input  wire logic             i_code_wr,
  input  wire logic [CODE_W-1:0] i_code_wdata,
  output logic      [CODE_W-1:0] o_code,
  // sequence phases from the sequencer
  input  wire logic             i_ph_squeeze,
  input  wire logic             i_ph_weld,
  input  wire logic             i_ph_hold,
  input  wire logic             i_ph_off,
  input  wire logic             i_off_done,
  input  wire logic             i_sequence_end_point,
  input  wire logic             i_last_weld,
  // pins, synchronised here
  input  wire logic             i_initiation,
  input  wire logic             i_thermal_limit_switch_open,
  input  wire logic             i_external_weld_inhibit_input,
  // control state and faults
  input  wire logic             i_weld_mode,
  input  wire logic             i_any_fault,
  input  wire logic             i_estop,
  input  wire logic             i_const_current,
  input  wire logic             i_hw_fault,
  input  wire logic             i_relay_fault,
  input  wire logic             i_scr_short,
  input  wire logic             i_line2_missing,
  input  wire logic             i_fault_group,
  input  wire logic             i_full_conduction,
  input  wire logic             i_serial_fitted,
  // current measurement
  input  wire logic             i_meas_done,
  input  wire logic             i_limit_check_result,
  input  wire logic [CUR_W-1:0] i_meas_current,
  // process output and actions
  output logic                  o_process_out,
  output logic                  o_valve3,
  output logic                  o_limit_flash,
  output logic                  o_seq_break,
  output logic                  o_mode_air_oil_retract,
  output logic                  o_mode_retract,
  output logic                  o_mode_half_cycle,
  // serial report
  output logic                  o_tx_req,
  output logic                  o_tx_out_of_window,
  output logic      [CUR_W-1:0] o_tx_current,
  // data display
  output logic                  o_show_current,
  output logic      [CUR_W-1:0] o_display_current
);
  typedef struct packed {
    logic [1:0]       tls_sync;
    logic [1:0]       nwi_sync;
    logic [1:0]       init_sync;
    logic             sqz;
    logic             weld;
    logic             after_off;
    logic             interlock;
    logic             last_out;
    logic             flash;
    logic             brk;
    logic             tx_req;
    logic             tx_out;
    logic [CUR_W-1:0] tx_cur;
    logic [CUR_W-1:0] disp_cur;
    logic             pout;
  } state_s;
  state_s st_q;
  state_s st_d;

  logic [CODE_W-1:0] code;
  logic              tls_open;
  logic              nwi_closed;
  logic              init_on;
  logic              out_evt;
  logic              good_end;

  pulse_if eos_p ();
  pulse_if v3_p ();

  function automatic logic flash_code(input logic [CODE_W-1:0] c);
    return (c == CODE_FLASH) || (c == CODE_FLASH_V3) ||
           (c == CODE_FLASH_BRK) || (c == CODE_FLASH_ALL);
  endfunction : flash_code

  function automatic logic break_code(input logic [CODE_W-1:0] c);
    return (c == CODE_FLASH_BRK) || (c == CODE_FLASH_ALL);
  endfunction : break_code

  code_store u_store (
    .i_mclk      (i_mclk),
    .i_sys_rst   (i_sys_rst),
    .i_prog_mode (i_prog_mode),
    .i_wr        (i_code_wr),
    .i_wdata     (i_code_wdata),
    .o_code      (code)
  );

  half_sec_pulse #(.CYCLES(P_PULSE_CYCLES)) u_eos_pulse (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .p         (eos_p.tmr)
  );

  half_sec_pulse #(.CYCLES(P_PULSE_CYCLES)) u_v3_pulse (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .p         (v3_p.tmr)
  );

  assign tls_open   = st_q.tls_sync[1];
  assign nwi_closed = st_q.nwi_sync[1];
  assign init_on    = st_q.init_sync[1];
  assign out_evt    = i_meas_done && i_limit_check_result;
  // last result must be inside the window, weld mode on, inhibit closed
  assign good_end   = i_sequence_end_point && !st_q.last_out && i_weld_mode && nwi_closed;

  assign eos_p.fire = (code == CODE_END_PULSE) && i_sequence_end_point;
  assign v3_p.fire  = (((code == CODE_FLASH_V3) || (code == CODE_FLASH_ALL)) && out_evt)
                   || ((code == CODE_END_V3) && good_end);

  always_comb begin
    st_d = st_q;
    st_d.tls_sync  = {st_q.tls_sync[0], i_thermal_limit_switch_open};
    st_d.nwi_sync  = {st_q.nwi_sync[0], i_external_weld_inhibit_input};
    st_d.init_sync = {st_q.init_sync[0], i_initiation};
    st_d.sqz       = i_ph_squeeze;
    st_d.weld      = i_ph_weld;
    st_d.brk       = 1'b0;
    st_d.tx_req    = 1'b0;
    if (i_meas_done) begin
      st_d.last_out = i_limit_check_result;
      st_d.disp_cur = i_meas_current;
    end
    // latch from end of off until initiation drops; set wins over clear
    if (!init_on) begin
      st_d.after_off = 1'b0;
    end
    if (i_off_done) begin
      st_d.after_off = 1'b1;
    end
    // interlock runs from squeeze completion to the end of weld
    if (st_q.weld && !i_ph_weld) begin
      st_d.interlock = 1'b0;
    end
    if (st_q.sqz && !i_ph_squeeze) begin
      st_d.interlock = 1'b1;
    end
    // flash holds until a good measurement or a non-flash code
    if ((i_meas_done && !i_limit_check_result) || !flash_code(code)) begin
      st_d.flash = 1'b0;
    end
    if (flash_code(code) && out_evt) begin
      st_d.flash = 1'b1;
    end
    if (break_code(code) && out_evt) begin
      st_d.brk = 1'b1;
    end
    // serial report only with the option fitted
    if (i_serial_fitted && i_meas_done) begin
      if (((code == CODE_TX_LAST) && (i_limit_check_result || i_last_weld))
          || ((code == CODE_TX_OUT) && i_limit_check_result)) begin
        st_d.tx_req = 1'b1;
        st_d.tx_out = i_limit_check_result;
        st_d.tx_cur = i_meas_current;
      end
    end
    case (code)
      CODE_WELD:      st_d.pout = i_ph_weld;
      CODE_WELD_HOLD: st_d.pout = i_ph_weld || i_ph_hold;
      CODE_HOLD:      st_d.pout = i_ph_hold;
      CODE_OFF:       st_d.pout = i_ph_off;
      CODE_AFTER_OFF: st_d.pout = st_d.after_off;
      CODE_END_PULSE: st_d.pout = eos_p.busy;
      CODE_ANY_FAULT: st_d.pout = i_any_fault || !i_weld_mode || !nwi_closed || i_prog_mode
                                  || i_estop || (i_const_current && st_q.last_out);
      CODE_THERMAL:   st_d.pout = tls_open;
      CODE_HW_FAULT:  st_d.pout = i_hw_fault || i_relay_fault;
      CODE_SCR_SHORT: st_d.pout = i_scr_short || i_line2_missing;
      CODE_FAULT_GRP: st_d.pout = i_fault_group || tls_open;
      CODE_FULL_COND: st_d.pout = i_full_conduction;
      CODE_WELD_OK:   st_d.pout = i_ph_weld && i_weld_mode && nwi_closed;
      CODE_INTERLOCK: st_d.pout = st_d.interlock;
      default:        st_d.pout = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // special functions take the output over from plain status
  assign o_mode_air_oil_retract = (code == CODE_AIR_OIL);
  assign o_mode_retract         = (code == CODE_RETRACT);
  assign o_mode_half_cycle      = (code == CODE_HALF_CYC);
  assign o_show_current         = (code == CODE_SHOW_CUR);
  assign o_code                 = code;
  assign o_process_out          = st_q.pout;
  assign o_valve3               = v3_p.busy;
  assign o_limit_flash          = st_q.flash;
  assign o_seq_break            = st_q.brk;
  assign o_tx_req               = st_q.tx_req;
  assign o_tx_out_of_window     = st_q.tx_out;
  assign o_tx_current           = st_q.tx_cur;
  assign o_display_current      = st_q.disp_cur;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  weld_follow_a: assert property (
    (code == CODE_WELD_HOLD) && (i_ph_weld || i_ph_hold) |=> o_process_out)
    else $error("weld or hold phase not shown on output");

  after_off_a: assert property (
    (code == CODE_AFTER_OFF) && i_off_done ##1 (code == CODE_AFTER_OFF) && init_on
    |=> o_process_out)
    else $error("output not held after off interval");

  end_pulse_a: assert property (
    (code == CODE_END_PULSE) && i_sequence_end_point && !eos_p.busy
    |=> eos_p.busy ##1 o_process_out)
    else $error("end pulse did not start");

  any_fault_a: assert property (
    (code == CODE_ANY_FAULT) && (i_estop || i_prog_mode) |=> o_process_out)
    else $error("stop or programming not shown");

  thermal_open_a: assert property (
    (code == CODE_THERMAL) |=> (o_process_out == $past(tls_open)))
    else $error("thermal switch state not shown");

  valve_pulse_a: assert property (
    (code == CODE_FLASH_V3) && out_evt && !v3_p.busy |=> o_valve3 && o_limit_flash)
    else $error("valve three or flash missing");

  // a second bad result in the very next cycle legally re-arms the break
  seq_break_a: assert property (
    break_code(code) && out_evt |=> o_seq_break && o_limit_flash
    ##1 (o_seq_break == $past(break_code(code) && out_evt)))
    else $error("sequence break not a single pulse");

  flash_only_a: assert property (
    (code == CODE_FLASH) && out_evt && !v3_p.busy |=> !o_valve3 && !o_seq_break && o_limit_flash)
    else $error("flash code took extra action");

  weld_inhibit_a: assert property (
    (code == CODE_WELD_OK) && !nwi_closed |=> !o_process_out)
    else $error("output on with inhibit open");

  serial_gate_a: assert property (
    (code == CODE_TX_OUT) && out_evt |=> (o_tx_req == $past(i_serial_fitted)))
    else $error("serial report gating wrong");

  good_end_a: assert property (
    (code == CODE_END_V3) && i_sequence_end_point && !v3_p.busy
    |=> (o_valve3 == $past(good_end)))
    else $error("valve three at end wrong");

  idle_code_a: assert property (
    (code == CODE_RSVD_A) || (code == CODE_RSVD_B) || (code == CODE_DISABLED)
    |=> !o_process_out ##0 !o_tx_req)
    else $error("idle code drove output");

  code_lock_a: assert property (
    !i_prog_mode |=> $stable(o_code))
    else $error("code changed outside programming");

  interlock_on_a: assert property (
    (code == CODE_INTERLOCK) && st_q.sqz && !i_ph_squeeze |=> o_process_out)
    else $error("interlock not raised after squeeze");

  const_cur_a: assert property (
    (code == CODE_ANY_FAULT) && i_const_current && st_q.last_out |=> o_process_out)
    else $error("constant current window fault not shown");

  hw_fault_a: assert property (
    (code == CODE_HW_FAULT) |=> (o_process_out == $past(i_hw_fault || i_relay_fault)))
    else $error("hardware or relay fault not shown");

  eos_pulse_c: cover property ((code == CODE_END_PULSE) && $fell(eos_p.busy));
  valve_end_c: cover property ((code == CODE_FLASH_ALL) && o_seq_break && o_valve3);
  tx_report_c: cover property ((code == CODE_TX_LAST) && o_tx_req && !o_tx_out_of_window);
  interlock_c: cover property ((code == CODE_INTERLOCK) && $fell(o_process_out));
endmodule : weld_process_output_select
`default_nettype wire

/* test/process_load_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far side: machine control input, lamp and breaker trip coil, seen as loads
module process_load_model (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  // driven loads
  input  wire logic       i_valve3,
  input  wire logic       i_process_out,
  // observed pulse figures
  output logic      [7:0] o_v3_cnt,
  output logic      [7:0] o_v3_len,
  output logic      [7:0] o_po_len
);
  logic [7:0] v3_run_q;
  logic [7:0] po_run_q;
  // figures latch only when a pulse ends, so a stuck output never reports
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      v3_run_q <= 8'h00;
      po_run_q <= 8'h00;
      o_v3_cnt <= 8'h00;
      o_v3_len <= 8'h00;
      o_po_len <= 8'h00;
    end else begin
      v3_run_q <= i_valve3 ? v3_run_q + 8'h01 : 8'h00;
      po_run_q <= i_process_out ? po_run_q + 8'h01 : 8'h00;
      if (!i_valve3 && v3_run_q != 8'h00) begin
        o_v3_len <= v3_run_q;
        o_v3_cnt <= o_v3_cnt + 8'h01;
      end
      if (!i_process_out && po_run_q != 8'h00) begin
        o_po_len <= po_run_q;
      end
    end
  end
endmodule : process_load_model
`default_nettype wire

/* test/weld_process_output_select_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module weld_process_output_select_tb;
  import po_sel_pkg::*;
  localparam int unsigned PW = 8;
  // phase codes and per-phase expectation: squeeze, weld, hold, off
  localparam logic [4:0] PC [6] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h14, 5'h13};
  localparam logic [3:0] PM [6] = '{4'h2, 4'h6, 4'h4, 4'h8, 4'h2, 4'h2};
  // code, input bit, expected level
  localparam logic [9:0] FT [16] = '{10'h141, 10'h143, 10'h153, 10'h155, 10'h171, 10'h1e5, 10'h1e7, 10'h209,
                                     10'h20b, 10'h22d, 10'h231, 10'h24f, 10'h000, 10'h2a0, 10'h3a0, 10'h180};
  // code, break, valve pulse
  localparam logic [6:0] LT [4] = '{7'h30, 7'h35, 7'h3a, 7'h6f};
  // code, serial fitted, out of window, last weld, expected request
  localparam logic [8:0] ST [6] = '{9'h16d, 9'h16b, 9'h168, 9'h17d, 9'h17a, 9'h174};
  logic             mclk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             prog = 1'b0;
  logic             wr = 1'b0;
  logic [4:0]       wdata = 5'h00;
  logic [3:0]       ph = 4'h0;
  logic             off_done = 1'b0;
  logic             end_pt = 1'b0;
  logic             last = 1'b0;
  logic             init = 1'b0;
  logic             fitted = 1'b0;
  logic             meas_done = 1'b0;
  logic             res = 1'b0;
  logic [15:0]      cur = 16'h0000;
  // fault and state levels; bit 9 means no weld, bit 10 inhibit open
  logic [11:0]      lv = 12'h000;
  logic [4:0]       code;
  logic             po, v3, flash, brk, m_ao, m_rt, m_hc, txr, txo, show;
  logic [15:0]      tx_cur, disp_cur;
  logic [7:0]       v3_cnt, v3_len, po_len, n;
  int               error_cnt = 0;
  int               cmp_count = 0;

  always #20 mclk = ~mclk;

  weld_process_output_select #(.P_PULSE_CYCLES(PW)) dut (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_prog_mode(prog), .i_code_wr(wr), .i_code_wdata(wdata),
    .o_code(code), .i_ph_squeeze(ph[0]), .i_ph_weld(ph[1]), .i_ph_hold(ph[2]), .i_ph_off(ph[3]),
    .i_off_done(off_done), .i_sequence_end_point(end_pt), .i_last_weld(last), .i_initiation(init),
    .i_thermal_limit_switch_open(lv[8]), .i_external_weld_inhibit_input(~lv[10]), .i_weld_mode(~lv[9]),
    .i_any_fault(lv[0]), .i_estop(lv[1]), .i_const_current(lv[11]), .i_hw_fault(lv[2]),
    .i_relay_fault(lv[3]), .i_scr_short(lv[4]), .i_line2_missing(lv[5]), .i_fault_group(lv[6]),
    .i_full_conduction(lv[7]), .i_serial_fitted(fitted), .i_meas_done(meas_done),
    .i_limit_check_result(res), .i_meas_current(cur), .o_process_out(po), .o_valve3(v3),
    .o_limit_flash(flash), .o_seq_break(brk), .o_mode_air_oil_retract(m_ao), .o_mode_retract(m_rt),
    .o_mode_half_cycle(m_hc), .o_tx_req(txr), .o_tx_out_of_window(txo), .o_tx_current(tx_cur),
    .o_show_current(show), .o_display_current(disp_cur));

  process_load_model load (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_valve3(v3), .i_process_out(po),
                           .o_v3_cnt(v3_cnt), .o_v3_len(v3_len), .o_po_len(po_len));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic set_code(input logic [4:0] c, input logic pm);
    @(posedge mclk);
    prog <= pm;
    wr <= 1'b1;
    wdata <= c;
    @(posedge mclk);
    prog <= 1'b0;
    wr <= 1'b0;
    cyc(3);
  endtask : set_code

  task automatic meas(input logic r, input logic [15:0] c);
    @(posedge mclk);
    meas_done <= 1'b1;
    res <= r;
    cur <= c;
    @(posedge mclk);
    meas_done <= 1'b0;
    #1;
  endtask : meas

  // one-cycle strobe of the end point or of off-done
  task automatic evt(input logic sel_end);
    @(posedge mclk);
    if (sel_end) end_pt <= 1'b1;
    else off_done <= 1'b1;
    @(posedge mclk);
    end_pt <= 1'b0;
    off_done <= 1'b0;
    #1;
  endtask : evt

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    cyc(2);
    set_code(5'h0a, 1'b0);
    chk("code refused", code, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      set_code(PC[i], 1'b1);
      chk("code", code, PC[i]);
      for (int p = 0; p < 4; p++) begin
        @(posedge mclk);
        ph <= 4'h1 << p;
        cyc(3);
        chk("phase out", po, PM[i][p]);
      end
      @(posedge mclk);
      ph <= 4'h0;
      cyc(2);
    end
    @(posedge mclk);
    lv[9] <= 1'b1;
    ph <= 4'h2;
    cyc(3);
    chk("weld without weld mode", po, 16'h0000);
    @(posedge mclk);
    lv <= 12'h400;
    cyc(5);
    chk("weld with inhibit open", po, 16'h0000);
    @(posedge mclk);
    lv <= 12'h000;
    ph <= 4'h0;
    $display("test phases done");
    for (int i = 0; i < 16; i++) begin
      set_code(FT[i][9:5], 1'b1);
      chk("fault idle", po, 16'h0000);
      @(posedge mclk);
      lv[FT[i][4:1]] <= 1'b1;
      cyc(5);
      chk("fault out", po, FT[i][0]);
      @(posedge mclk);
      lv <= 12'h000;
      cyc(5);
      chk("fault clear", po, 16'h0000);
    end
    $display("test faults done");
    for (int c = 7; c < 10; c++) begin
      set_code(5'(c), 1'b1);
      chk("mode", {m_ao, m_rt, m_hc}, 3'b100 >> (c - 7));
      chk("mode out", po, 16'h0000);
    end
    set_code(5'h05, 1'b1);
    @(posedge mclk);
    init <= 1'b1;
    cyc(4);
    chk("after off idle", po, 16'h0000);
    evt(1'b0);
    cyc(4);
    chk("after off set", po, 16'h0001);
    @(posedge mclk);
    init <= 1'b0;
    cyc(5);
    chk("after off clear", po, 16'h0000);
    set_code(5'h06, 1'b1);
    evt(1'b1);
    cyc(PW + 4);
    chk("end pulse length", po_len, 16'(PW));
    $display("test sequence codes done");
    for (int i = 0; i < 4; i++) begin
      set_code(LT[i][6:2], 1'b1);
      n = v3_cnt;
      meas(1'b1, 16'h0100 + 16'(i));
      chk("flash", flash, 16'h0001);
      chk("break", brk, LT[i][1]);
      meas(1'b1, 16'h0110);
      cyc(PW + 4);
      chk("valve pulses", v3_cnt - n, LT[i][0]);
      if (LT[i][0]) chk("valve length", v3_len, 16'(PW));
      chk("limit out", po, 16'h0000);
      meas(1'b0, 16'h0120);
      cyc(2);
      chk("flash clear", flash, 16'h0000);
    end
    set_code(5'h1c, 1'b1);
    n = v3_cnt;
    meas(1'b0, 16'h0130);
    evt(1'b1);
    cyc(PW + 4);
    chk("end valve good", v3_cnt - n, 16'h0001);
    meas(1'b1, 16'h0140);
    evt(1'b1);
    cyc(PW + 4);
    chk("end valve bad", v3_cnt - n, 16'h0001);
    // constant current: output follows the latest window result
    set_code(5'h0a, 1'b1);
    @(posedge mclk);
    lv[11] <= 1'b1;
    meas(1'b0, 16'h0150);
    cyc(1);
    chk("const current in", po, 16'h0000);
    meas(1'b1, 16'h0160);
    cyc(1);
    chk("const current out", po, 16'h0001);
    @(posedge mclk);
    lv <= 12'h000;
    $display("test limit codes done");
    for (int i = 0; i < 6; i++) begin
      set_code(ST[i][8:4], 1'b1);
      @(posedge mclk);
      fitted <= ST[i][3];
      last <= ST[i][1];
      meas(ST[i][2], 16'h0200 + 16'(i));
      chk("tx request", txr, ST[i][0]);
      if (ST[i][0]) chk("tx current", tx_cur, 16'h0200 + 16'(i));
      if (ST[i][0]) chk("tx result", txo, ST[i][2]);
    end
    set_code(5'h19, 1'b1);
    chk("show current", show, 16'h0001);
    meas(1'b0, 16'h1234);
    chk("display current", disp_cur, 16'h1234);
    $display("test report codes done");
    conclude();
  end
endmodule : weld_process_output_select_tb
`default_nettype wire
